//--- design/rrc_regs.svh
// Constants for the rotate-right-through-carry execution block
`ifndef RRC_REGS_SVH
`define RRC_REGS_SVH
`define RRC_OPC_TOP6 6'h0C
`define RRC_OPC_HI 15
`define RRC_OPC_LO 10
`define RRC_D_BIT 9
`define RRC_A_BIT 8
`define RRC_ILO_LIMIT 8'h5F
`define RRC_ACCESS_SPLIT 8'h60
`define RRC_ACCESS_HI_BANK 4'hF
`define RRC_BANK_W 4
`define RRC_PHASES 4
`define RRC_N_BIT 4
`define RRC_Z_BIT 2
`define RRC_C_BIT 0
`endif

//--- design/rrc_pkg.sv
// Types for the rotate-right-through-carry execution block
package rrc_pkg;
	typedef enum logic [1:0] {RRC_Q1, RRC_Q2, RRC_Q3, RRC_Q4} rrc_phase_e;
	typedef logic [7:0] rrc_byte_t;
	typedef logic [11:0] rrc_addr_t;
endpackage

//--- design/rrc_rotator.sv
// Rotate one byte right through a carry bit
`timescale 1ns/100ps
module rrc_rotator
(
	// Operand and carry in
	input wire rrc_pkg::rrc_byte_t operand_i,
	input wire logic carry_i,
	// Result and flags out
	output rrc_pkg::rrc_byte_t result_o,
	output logic carry_o,
	output logic negative_o,
	output logic zero_o
);
	import rrc_pkg::*;
	assign result_o = {carry_i, operand_i[7:1]};
	assign carry_o = operand_i[0];
	assign negative_o = result_o[7];
	assign zero_o = (result_o == 8'h00);
endmodule

//--- design/rrc_exec.sv
// Four-phase execution of the rotate-right-through-carry instruction
`timescale 1ns/100ps
`include "rrc_regs.svh"
module rrc_exec
(
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Instruction in
	input wire logic [15:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic ext_set_en_i,
	input wire logic [`RRC_BANK_W-1:0] bank_select_register_i,
	input wire rrc_pkg::rrc_addr_t index_base_i,
	// Data memory
	output rrc_pkg::rrc_addr_t mem_addr_o,
	output logic mem_rd_o,
	input wire rrc_pkg::rrc_byte_t mem_rdata_i,
	output logic mem_wr_o,
	output rrc_pkg::rrc_byte_t mem_wdata_o,
	// Working register
	output logic w_wr_o,
	output rrc_pkg::rrc_byte_t w_wdata_o,
	// Status register
	input wire logic [7:0] status_i,
	output logic status_wr_o,
	output logic [7:0] status_wdata_o,
	// Progress
	output rrc_pkg::rrc_phase_e phase_o,
	output logic busy_o,
	output logic done_o
);
	import rrc_pkg::*;

	rrc_phase_e phase;
	rrc_phase_e next_phase;
	logic active;
	logic dest_f;
	rrc_addr_t addr;
	rrc_byte_t operand;
	rrc_byte_t result;
	logic carry_new;
	logic neg_new;
	logic zero_new;
	logic carry_in;
	rrc_byte_t res_q;
	logic [7:0] status_q;
	logic wr_mem_q;
	logic wr_w_q;
	logic st_wr_q;
	logic done_q;

	// Decode
	wire is_rrc = instr_valid_i && (instr_i[`RRC_OPC_HI:`RRC_OPC_LO] == `RRC_OPC_TOP6);
	wire d_bit = instr_i[`RRC_D_BIT];
	wire a_bit = instr_i[`RRC_A_BIT];
	wire [7:0] f_field = instr_i[7:0];
	wire use_ilo = !a_bit && ext_set_en_i && (f_field <= `RRC_ILO_LIMIT);
	wire acc_hi = f_field >= `RRC_ACCESS_SPLIT;
	wire [3:0] acc_bank = acc_hi ? `RRC_ACCESS_HI_BANK : 4'h0;
	wire rrc_addr_t ilo_addr = index_base_i + {4'h0, f_field};
	wire rrc_addr_t bank_addr = {bank_select_register_i, f_field};
	wire rrc_addr_t acc_addr = {acc_bank, f_field};
	wire rrc_addr_t next_addr = use_ilo ? ilo_addr : (a_bit ? bank_addr : acc_addr);

	assign carry_in = status_i[`RRC_C_BIT];

	rrc_rotator u_rot
	(
		.operand_i(operand),
		.carry_i(carry_in),
		.result_o(result),
		.carry_o(carry_new),
		.negative_o(neg_new),
		.zero_o(zero_new)
	);

	// Phase sequencing
	always_comb
	begin
		next_phase = phase;
		case (phase)
			RRC_Q1: next_phase = is_rrc ? RRC_Q2 : RRC_Q1;
			RRC_Q2: next_phase = RRC_Q3;
			RRC_Q3: next_phase = RRC_Q4;
			RRC_Q4: next_phase = RRC_Q1;
			default: next_phase = RRC_Q1;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			phase <= RRC_Q1;
		else if (ce_i)
			phase <= next_phase;
	end

	// Operand capture
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			addr <= 12'h000;
			dest_f <= 1'b0;
			operand <= 8'h00;
		end
		else if (ce_i)
		begin
			if (phase == RRC_Q1 && is_rrc)
			begin
				addr <= next_addr;
				dest_f <= d_bit;
			end
			if (phase == RRC_Q2)
				operand <= mem_rdata_i;
		end
	end

	// Result and status
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			res_q <= 8'h00;
			status_q <= 8'h00;
		end
		else if (ce_i && phase == RRC_Q3)
		begin
			res_q <= result;
			status_q <= status_i;
			status_q[`RRC_C_BIT] <= carry_new;
			status_q[`RRC_N_BIT] <= neg_new;
			status_q[`RRC_Z_BIT] <= zero_new;
		end
	end

	// Write strobes
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wr_mem_q <= 1'b0;
			wr_w_q <= 1'b0;
			st_wr_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (ce_i)
		begin
			wr_mem_q <= (phase == RRC_Q3) && dest_f;
			wr_w_q <= (phase == RRC_Q3) && !dest_f;
			st_wr_q <= (phase == RRC_Q3);
			done_q <= (phase == RRC_Q4);
		end
	end

	assign active = (phase != RRC_Q1);
	assign mem_addr_o = addr;
	assign mem_rd_o = (phase == RRC_Q2);
	assign mem_wr_o = wr_mem_q && ce_i;
	assign mem_wdata_o = res_q;
	assign w_wr_o = wr_w_q && ce_i;
	assign w_wdata_o = res_q;
	assign status_wr_o = st_wr_q && ce_i;
	assign status_wdata_o = status_q;
	assign phase_o = phase;
	assign busy_o = active;
	assign done_o = done_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	sequence s_start;
		ce_i && phase == RRC_Q1 && is_rrc;
	endsequence
	sequence s_run3;
		ce_i [*3];
	endsequence

	four_phase_a: assert property (s_start ##1 s_run3 |=> phase == RRC_Q1)
		else $error("Rotate did not end after four phases");
	dest_mem_a: assert property (mem_wr_o |-> dest_f && !w_wr_o)
		else $error("Memory written with W destination");
	dest_w_a: assert property (w_wr_o |-> !dest_f && !mem_wr_o)
		else $error("W written with file destination");
	rot_data_a: assert property (ce_i && phase == RRC_Q3 |=>
		res_q == {$past(status_i[`RRC_C_BIT]), operand[7:1]})
		else $error("Rotate result wrong");
	carry_out_a: assert property (ce_i && phase == RRC_Q3 |=> status_q[0] == operand[0])
		else $error("Carry not taken from bit 0");
	flags_nz_a: assert property (ce_i && phase == RRC_Q3 |=>
		status_q[`RRC_N_BIT] == res_q[7] && status_q[`RRC_Z_BIT] == (res_q == 8'h00))
		else $error("N or Z wrong");
	flags_other_a: assert property (ce_i && phase == RRC_Q3 |=>
		status_q[7:5] == $past(status_i[7:5])
		&& status_q[3] == $past(status_i[3])
		&& status_q[1] == $past(status_i[1]))
		else $error("Unrelated status bit changed");
	bank_sel_a: assert property ((s_start and a_bit) |=>
		addr == {$past(bank_select_register_i), $past(instr_i[7:0])})
		else $error("Banked address wrong");
	decode_a: assert property (ce_i && phase == RRC_Q1 && !is_rrc |=> phase == RRC_Q1)
		else $error("Started on foreign opcode");
	ilo_mode_a: assert property ((s_start and use_ilo) |=>
		addr == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
		else $error("Indexed offset address wrong");
	addr_hold_a: assert property (ce_i && phase == RRC_Q2 |=> $stable(addr))
		else $error("Address moved during operation");
	acc_bank_a: assert property ((s_start and !a_bit and !use_ilo) |=>
		addr[7:0] == $past(instr_i[7:0])
		&& addr[11:8] == (($past(instr_i[7:0]) < `RRC_ACCESS_SPLIT) ? 4'h0 : `RRC_ACCESS_HI_BANK))
		else $error("Access bank address wrong");
	read_next_a: assert property (s_start |=> mem_rd_o && busy_o)
		else $error("Operand not read after decode");
	write_q4_a: assert property (s_start ##1 s_run3 |-> status_wr_o && (mem_wr_o ^ w_wr_o))
		else $error("Destination write missing in last phase");
	done_pulse_a: assert property (done_o && ce_i |=> !done_o)
		else $error("Done held longer than one cycle");
endmodule

//--- verif/rrc_core_model.sv
// Data memory, working register and status register model
`timescale 1ns/100ps
module rrc_core_model
(
	// Clock
	input wire logic clk_sys_i,
	// Data memory
	input wire rrc_pkg::rrc_addr_t mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire rrc_pkg::rrc_byte_t mem_wdata_i,
	output rrc_pkg::rrc_byte_t mem_rdata_o,
	// Working and status registers
	input wire logic w_wr_i,
	input wire rrc_pkg::rrc_byte_t w_wdata_i,
	input wire logic status_wr_i,
	input wire logic [7:0] status_wdata_i,
	output logic [7:0] status_o,
	// Test preload
	input wire logic pre_i,
	input wire rrc_pkg::rrc_addr_t pre_addr_i,
	input wire rrc_pkg::rrc_byte_t pre_data_i,
	input wire logic [7:0] pre_status_i
);
	import rrc_pkg::*;
	rrc_byte_t mem [0:4095];
	rrc_byte_t w_reg;
	rrc_byte_t last;
	// Released read bus shows inverted last value
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;
	always @(posedge clk_sys_i)
	begin
		if (mem_rd_i)
			last <= mem[mem_addr_i];
		if (mem_wr_i)
			mem[mem_addr_i] <= mem_wdata_i;
		if (w_wr_i)
			w_reg <= w_wdata_i;
		if (pre_i)
		begin
			mem[pre_addr_i] <= pre_data_i;
			status_o <= pre_status_i;
		end
		if (status_wr_i)
			status_o <= status_wdata_i;
	end
endmodule

//--- verif/tb.sv
// Testbench for the rotate-right-through-carry execution block
`timescale 1ns/100ps
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) \
	begin \
		num_errors++; \
		$display("[FAIL] %0t mismatch", $time); \
	end \
end
module tb;
	import rrc_pkg::*;
	localparam rrc_byte_t FLIST [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF};
	logic clk_sys_i = 0;
	logic reset_i = 1;
	logic ce = 1;
	logic instr_valid_i = 0;
	logic ext_set_en_i = 0;
	logic [15:0] instr_i = 0;
	logic [3:0] bank_sel = 0;
	logic pre = 0;
	rrc_addr_t pre_addr = 0;
	rrc_byte_t pre_data = 0;
	logic [7:0] pre_status = 0;
	rrc_phase_e phase;
	int base;
	rrc_addr_t index_base = 12'h2A0;
	rrc_addr_t mem_addr, rd_addr;
	rrc_byte_t mem_rdata, mem_wdata, w_wdata;
	logic [7:0] status, status_wdata;
	logic mem_rd, mem_wr, w_wr, status_wr, busy, done;
	int num_errors = 0;
	int checked = 0;
	int mw, ww, sw;
	always #2 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		if (mem_rd)
			rd_addr <= mem_addr;
		mw <= mw + int'(mem_wr);
		ww <= ww + int'(w_wr);
		sw <= sw + int'(status_wr);
	end
	rrc_exec u_rrc_exec (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce),
		.instr_i(instr_i), .instr_valid_i(instr_valid_i), .ext_set_en_i(ext_set_en_i),
		.bank_select_register_i(bank_sel), .index_base_i(index_base), .mem_addr_o(mem_addr),
		.mem_rd_o(mem_rd), .mem_rdata_i(mem_rdata), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata),
		.w_wr_o(w_wr), .w_wdata_o(w_wdata), .status_i(status), .status_wr_o(status_wr),
		.status_wdata_o(status_wdata), .phase_o(phase), .busy_o(busy), .done_o(done));
	rrc_core_model u_rrc_core_model (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr),
		.mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata),
		.w_wr_i(w_wr), .w_wdata_i(w_wdata), .status_wr_i(status_wr),
		.status_wdata_i(status_wdata), .status_o(status), .pre_i(pre), .pre_addr_i(pre_addr),
		.pre_data_i(pre_data), .pre_status_i(pre_status));
	task automatic run_op(input logic d, a, ext, input rrc_byte_t f, v, input logic c,
		input logic [3:0] bank, input int stall);
		rrc_byte_t r;
		rrc_addr_t ea;
		logic [7:0] st;
		int n;
		int m0;
		int w0;
		int s0;
		r = {c, v[7:1]};
		ea = a ? {bank, f} : (ext && f <= 8'h5F) ? index_base + 12'(f)
			: {(f < 8'h60) ? 4'h0 : 4'hF, f};
		st = {4'hA, 3'b011, c};
		m0 = mw;
		w0 = ww;
		s0 = sw;
		@(posedge clk_sys_i);
		bank_sel <= bank;
		pre_addr <= ea;
		pre_data <= v;
		pre_status <= st;
		pre <= 1'b1;
		ext_set_en_i <= ext;
		instr_i <= {6'b001100, d, a, f};
		instr_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		pre <= 1'b0;
		instr_valid_i <= 1'b0;
		#1;
		`CHK(phase, RRC_Q2)
		`CHK(busy, 1'b1)
		`CHK(mem_rd, 1'b1)
		`CHK(done, 1'b0)
		repeat (2) @(posedge clk_sys_i);
		// Freeze in the write phase: strobes must stay masked
		if (stall > 0)
		begin
			ce <= 1'b0;
			repeat (stall) @(posedge clk_sys_i);
			ce <= 1'b1;
		end
		n = 3 + stall;
		#1;
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		`CHK(n, 4 + stall)
		`CHK(rd_addr, ea)
		`CHK(d ? u_rrc_core_model.mem[ea] : u_rrc_core_model.w_reg, r)
		`CHK(u_rrc_core_model.status_o[0], v[0])
		`CHK(mw - m0, int'(d))
		`CHK(ww - w0, int'(!d))
		`CHK(sw - s0, 1)
		`CHK(u_rrc_core_model.status_o, {st[7:5], r[7], st[3], r == 8'h00, st[1], v[0]})
	endtask
	task automatic wrap_up;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 4; k++)
			for (int j = 0; j < 8; j++)
				run_op(j[0], j[1], j[2], FLIST[k], j[0] ? 8'h01 : 8'hA6 ^ 8'(j * 16 + k),
					j[1] ^ k[0], 4'(3 + k), (k == 1) ? j : 0);
		$display("test rotate table done");
		base = mw + ww + sw;
		@(posedge clk_sys_i);
		instr_i <= 16'h3200;
		instr_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b0;
		reset_i <= 1'b1;
		@(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1;
		`CHK(busy, 1'b0)
		`CHK(phase, RRC_Q1)
		`CHK(mw + ww + sw, base)
		$display("test reset in flight done");
		base = mw + ww + sw;
		@(posedge clk_sys_i);
		instr_i <= 16'h3400;
		instr_valid_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		instr_valid_i <= 1'b0;
		#1;
		`CHK(busy, 1'b0)
		`CHK(mw + ww + sw, base)
		$display("test foreign opcode done");
		wrap_up();
	end
	initial
	begin
		repeat (2000) @(posedge clk_sys_i);
		num_errors++;
		wrap_up();
	end
endmodule
